//--- rtl/dpsc_port_ctrl.v
`include "dpsc_defines.vh"
`default_nettype none

module dpsc_port_ctrl (
	// Clock and reset
	input wire clk,
	input wire srst,
	// User request
	input wire req_valid,
	input wire req_write,
	input wire req_sem,
	input wire [`DPSC_ADDR_W-1:0] req_addr,
	input wire [`DPSC_DATA_W-1:0] req_wdata,
	output reg req_ready,
	// User answer
	output reg rsp_valid,
	output reg [`DPSC_DATA_W-1:0] rsp_rdata,
	output reg sem_owned,
	// Memory port pins
	output reg array_select_n,
	output reg semaphore_select_n,
	output reg rw_n,
	output reg oe_n,
	output reg [`DPSC_ADDR_W-1:0] addr,
	output reg [`DPSC_DATA_W-1:0] dq_out,
	output reg dq_oe,
	input wire [`DPSC_DATA_W-1:0] dq_in
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_PULSE = 3'h2;
	localparam [2:0] ST_HOLD = 3'h3;
	localparam [2:0] ST_READ = 3'h4;

	localparam integer PULSE_I = `DPSC_CEIL_CYC(`DPSC_PULSE_NS);
	localparam integer READ_I = `DPSC_CEIL_CYC(`DPSC_TAA_NS) + `DPSC_SYNC_STAGES;
	localparam [3:0] PULSE_CYC = PULSE_I[3:0];
	localparam [3:0] READ_CYC = READ_I[3:0];

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	reg wr_reg;
	reg sem_reg;
	reg [`DPSC_DATA_W-1:0] sync1_reg;
	reg [`DPSC_DATA_W-1:0] sync2_reg;

	// A request is taken on the edge that sees both valid and ready
	wire take;
	assign take = req_valid && req_ready;

	// Data pins are asynchronous to clk; first stage is read only by the second
	always @(posedge clk) begin
		if (srst) begin
			sync1_reg <= `DPSC_DATA_IDLE;
			sync2_reg <= `DPSC_DATA_IDLE;
		end else begin
			sync1_reg <= dq_in;
			sync2_reg <= sync1_reg;
		end
	end

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid && req_ready) begin
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				cnt_next = `DPSC_CNT_ONE;
				state_next = wr_reg ? ST_PULSE : ST_READ;
			end
			ST_PULSE: begin
				cnt_next = cnt_reg + `DPSC_CNT_ONE;
				if (cnt_reg == PULSE_CYC) begin
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				state_next = ST_IDLE;
			end
			ST_READ: begin
				cnt_next = cnt_reg + `DPSC_CNT_ONE;
				if (cnt_reg == READ_CYC) begin
					state_next = ST_HOLD;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Handshake toward the user; ready stays low for the whole access
	always @(posedge clk) begin
		if (srst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
		end else begin
			// One cycle pulse per finished access
			rsp_valid <= (state_reg == ST_HOLD);
			if (state_reg == ST_IDLE) begin
				req_ready <= ~take;
			end else if (state_reg == ST_HOLD) begin
				req_ready <= 1'b1;
			end
		end
	end

	// Answer registers kept apart from the pin sequencer
	always @(posedge clk) begin
		if (srst) begin
			rsp_rdata <= `DPSC_DATA_IDLE;
			sem_owned <= 1'b0;
		end else begin
			if (state_reg == ST_READ && cnt_reg == READ_CYC) begin
				rsp_rdata <= sync2_reg;
				if (sem_reg) begin
					// Reading zero means this side holds the latch
					sem_owned <= ~sync2_reg[0];
				end
			end
			if (state_reg == ST_HOLD && sem_reg && wr_reg && dq_out[0]) begin
				// Ownership is bookkeeping only; the latch itself is never read back here
				sem_owned <= 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= `DPSC_CNT_ZERO;
			wr_reg <= 1'b0;
			sem_reg <= 1'b0;
			array_select_n <= 1'b1;
			semaphore_select_n <= 1'b1;
			rw_n <= 1'b1;
			oe_n <= 1'b1;
			addr <= `DPSC_ADDR_IDLE;
			dq_out <= `DPSC_DATA_IDLE;
			dq_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						wr_reg <= req_write;
						sem_reg <= req_sem;
						// Selects and read/write are all high here, so the address may move
						if (req_sem) begin
							addr <= {{(`DPSC_ADDR_W-`DPSC_SEM_ADDR_W){1'b0}},
								req_addr[`DPSC_SEM_ADDR_W-1:0]};
							dq_out <= {`DPSC_DATA_W{req_wdata[0]}};
						end else begin
							addr <= req_addr;
							dq_out <= req_wdata;
						end
					end
				end
				ST_SETUP: begin
					// Address valid from here gives the address-to-end time across the pulse
					if (wr_reg) begin
						// Select and write fall together, so device outputs never turn on
						rw_n <= 1'b0;
						oe_n <= 1'b1;
						dq_oe <= 1'b1;
					end else begin
						oe_n <= 1'b0;
					end
					array_select_n <= sem_reg;
					semaphore_select_n <= ~sem_reg;
				end
				ST_PULSE: begin
					if (cnt_reg == PULSE_CYC) begin
						// Write ends on both strobes rising; data still driven for the hold
						rw_n <= 1'b1;
						array_select_n <= 1'b1;
						semaphore_select_n <= 1'b1;
					end
				end
				ST_HOLD: begin
					// A full clock of hold beyond the write end covers the data hold time
					dq_oe <= 1'b0;
					oe_n <= 1'b1;
				end
				ST_READ: begin
					if (cnt_reg == READ_CYC) begin
						array_select_n <= 1'b1;
						semaphore_select_n <= 1'b1;
					end
				end
				default: begin
					dq_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

//--- rtl/dpsc_defines.vh
`ifndef DPSC_DEFINES_VH
`define DPSC_DEFINES_VH

// Clock period of the host logic
`define DPSC_CLK_NS 25

// Write timing of the fastest grade, in ns
`define DPSC_TWC_NS 45
`define DPSC_TEW_NS 40
`define DPSC_TAW_NS 40
`define DPSC_TWP_NS 40
`define DPSC_TDW_NS 20
`define DPSC_TWZ_NS 20
`define DPSC_TDH_NS 3
// Read access time of the fastest grade, in ns
`define DPSC_TAA_NS 45

// Least times round up to whole clock cycles
`define DPSC_CEIL_CYC(ns) (((ns) + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`define DPSC_MAX(a, b) (((a) > (b)) ? (a) : (b))

// Write pulse with output enable low: the larger of pulse width and turn-off plus data valid
`define DPSC_PULSE_NS `DPSC_MAX(`DPSC_MAX(`DPSC_TWP_NS, `DPSC_TEW_NS), `DPSC_TWZ_NS + `DPSC_TDW_NS)

// Two synchroniser stages on the data pins
`define DPSC_SYNC_STAGES 2

// Pin widths
`define DPSC_ADDR_W 12
`define DPSC_DATA_W 8
`define DPSC_SEM_ADDR_W 3

// Pin idle levels and counter constants
`define DPSC_ADDR_IDLE 12'h000
`define DPSC_DATA_IDLE 8'h00
`define DPSC_CNT_ZERO 4'h0
`define DPSC_CNT_ONE 4'h1

`endif

//--- test/dpsc_properties.sv
`default_nettype none
module dpsc_props(input wire logic clk,srst,req_valid,req_write,req_ready,rsp_valid,
	array_select_n,semaphore_select_n,rw_n,oe_n,dq_oe,input wire logic [11:0] addr);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (srst);
property p_sel; !array_select_n|->semaphore_select_n; endproperty
a_sel: assert property(p_sel) else $error("two selects");
property p_hsel; !rw_n|->!(array_select_n&&semaphore_select_n); endproperty
a_hsel: assert property(p_hsel) else $error("no select");
property p_adr; $changed(addr)|->rw_n&&$past(rw_n); endproperty
a_adr: assert property(p_adr) else $error("addr moved");
property p_pw; $fell(rw_n)|->!rw_n##1 !rw_n##1 rw_n; endproperty
a_pw: assert property(p_pw) else $error("pulse");
property p_oe; !rw_n|->oe_n; endproperty
a_oe: assert property(p_oe) else $error("oe low");
property p_dw; !rw_n|->dq_oe&&$stable(addr); endproperty
a_dw: assert property(p_dw) else $error("setup");
property p_dh; $rose(rw_n)|->dq_oe; endproperty
a_dh: assert property(p_dh) else $error("hold");
property p_wc; req_valid&&req_ready&&req_write|->##5 rsp_valid; endproperty
a_wc: assert property(p_wc) else $error("cycle");
c_w: cover property(!rw_n&&!array_select_n);
c_s: cover property(!rw_n&&!semaphore_select_n);
c_r: cover property(!oe_n);
endmodule
bind dpsc_port_ctrl dpsc_props u_dpsc_props(.*);
`default_nettype wire

//--- test/dpsc_ram_model.sv
`default_nettype none
module dpsc_ram_model(input wire logic array_select_n,semaphore_select_n,rw_n,oe_n,dq_oe,
	input wire logic [11:0] addr,input wire logic [7:0] dq_out,output logic [7:0] dq_in);
timeunit 1ns;
timeprecision 1ps;
logic [7:0] mem[4096];
logic [7:0] flag=8'hff;
wire wr=!rw_n&&(!array_select_n||!semaphore_select_n);
wire #5 sd=semaphore_select_n;
wire [11:0] #5 ad=addr;
// Data is taken 3 ns after the write ends, so early release writes garbage
always @(negedge wr) begin
	#3;
	if (!sd) flag[ad[2:0]]<=dq_oe?dq_out[0]:!dq_out[0];
	else mem[ad]<=dq_oe?dq_out:~dq_out;
end
assign dq_in=rw_n&&!oe_n&&!array_select_n?mem[addr]:
	rw_n&&!oe_n&&!semaphore_select_n?{8{flag[addr[2:0]]}}:~mem[addr];
endmodule
`default_nettype wire

//--- test/dpsc_port_ctrl_tb_top.sv
`default_nettype none
module dpsc_port_ctrl_tb_top;
timeunit 1ns;
timeprecision 1ps;
logic clk=0,srst=1,req_valid=0,req_write=0,req_sem=0;
logic [11:0] req_addr=0;
logic [7:0] req_wdata=0,rd,sh[4];
wire req_ready,rsp_valid,sem_owned,array_select_n,semaphore_select_n,rw_n,oe_n,dq_oe;
wire [11:0] addr;
wire [7:0] rsp_rdata,dq_out,dq_in;
int err_count=0,samples_checked=0,seed=32'he446_6f1c;
always #12.5 clk=~clk;
dpsc_port_ctrl u_dpsc_port_ctrl(.*);
dpsc_ram_model u_dpsc_ram_model(.*);
task chk(string n,logic [7:0] e,s);
	samples_checked++;
	if (s!==e) begin
		err_count++;
		$display("FAIL %s exp %h got %h",n,e,s);
	end
endtask
task op(logic w,s,logic [11:0] a,logic [7:0] d);
	int k;
	@(negedge clk) {req_valid,req_write,req_sem,req_addr,req_wdata}={1'b1,w,s,a,d};
	k=0;
	while (req_ready!==1&&k<20) begin
		@(negedge clk);
		k++;
	end
	if (k==20) begin
		err_count++;
		$display("FAIL req_ready exp 1 got %b",req_ready);
	end
	@(negedge clk) req_valid=0;
	k=0;
	while (rsp_valid!==1&&k<12) begin
		@(negedge clk);
		k++;
	end
	if (k==12) begin
		err_count++;
		$display("FAIL rsp_valid exp 1 got %b",rsp_valid);
	end
	rd=rsp_rdata;
endtask
task give_verdict;
	$display("mismatches %0d checks %0d",err_count,samples_checked);
	if (err_count==0&&samples_checked>0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
initial begin
	#50us err_count++;
	give_verdict;
end
initial begin
	repeat(16) @(posedge clk);
	@(negedge clk) srst=0;
	// Corner addresses, writes then reads back to back
	for (int i=0;i<8;i++) begin
		if (i<4) sh[i]=$random(seed);
		op(i<4,0,{i[1:0],{10{i[0]}}},sh[i%4]);
		if (i>3) chk("array",sh[i%4],rd);
	end
	for (int j=0;j<8;j++) begin
		op(1,1,{9'($random(seed)),3'(j)},8'hfe);
		op(0,1,{9'($random(seed)),3'(j)},0);
		chk("own",8'h00,rd);
		chk("flag",8'h01,{7'h0,sem_owned});
		op(1,1,12'(j),8'h01);
		op(0,1,12'(j),0);
		chk("free",8'hff,rd);
	end
	give_verdict;
end
endmodule
`default_nettype wire
